// ==== hw/rtc_ctrl_irq.sv ====
// Clock control, periodic interrupt and register slave of the clock block
// Summary of operation
// R1: Run bit halts or runs both counters
// R2: Hour format bit selects 0-11 or 0-23
// R3: Afternoon flag 0 morning, 1 afternoon
// R4: Soft reset holds clock registers and control
// R5: Software clears soft reset bit afterwards
// R6: Standby or soft reset clears top bits
// R7: Standby or soft reset clears enable register
// R8: Reserved control bits always read zero
// R9: Enabled time-of-day event sets clock request flag
// R10: Overflow interrupt only when its enable set
// R11: Weekly interrupt only while week enabled
// R12: Daily interrupt only while day enabled
// R13: Hourly interrupt only while hour enabled
// R14: Minute interrupt only while minute enabled
// R15: Second interrupt only while second enabled
// R16: Twelve-hour wrap toggles afternoon flag
// R17: Hour held as BCD tens and ones
// R18: Writes to reserved bits are ignored
`timescale 1ns/100ps

module rtc_ctrl_irq
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and power-on reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Device-level reset pins, synchronous
    input  wire logic        standbyInN,
    input  wire logic        systemResetIn,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irqOut
);

    localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

    rtc_ctrl_one_t ctrl_r;
    rtc_evt_t      irqEn_r;
    logic [5:0]    hour_r;
    logic [5:0]    sec_r;
    logic [5:0]    min_r;
    logic [2:0]    week_r;
    logic [7:0]    frc_r;
    logic          freeRunMode_r;
    rtc_stat_t     stat_r;
    rtc_stat_t     statSet;
    rtc_stat_t     intEn_r;
    logic [TICK_W-1:0] tickCnt_r;
    logic          ack_r;
    logic [31:0]   dat_r;
    logic          irq_r;

    logic          busReq;
    logic          wrStb;
    logic          laneLow;
    logic          clearClock;
    logic          running;
    logic          tick;
    logic          clkTick;
    logic          frcTick;
    logic          hourWrap;
    logic          hourEnd;
    logic          midnight;
    logic [5:0]    hourInc;
    rtc_evt_t      evt;
    logic [31:0]   rdData;

    // Bus decode: one wait state, writes land on the acked edge
    assign busReq  = wb_cyc_i && wb_stb_i;
    assign laneLow = wb_sel_i[0];
    assign wrStb   = busReq && wb_we_i && ack_r && laneLow;

    // Standby and soft reset share one synchronous clear path
    assign clearClock = !standbyInN || ctrl_r.softReset;        // R4

    assign running = ctrl_r.run && !clearClock;                 // R1

    // Second divider; halted with the clock so a restart is aligned
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt_r <= '0;
        end else if (!running || ctrl_r.softReset) begin        // R1
            tickCnt_r <= '0;
        end else if (tickCnt_r == TICK_W'(TICK_CYCLES - 1)) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + TICK_W'(1);
        end
    end

    assign tick    = running && (tickCnt_r == TICK_W'(TICK_CYCLES - 1));
    assign clkTick = tick && !freeRunMode_r;
    assign frcTick = tick && freeRunMode_r;

    // Hour arithmetic
    assign hourEnd  = ctrl_r.fmt24 ? (hour_r == HOUR_24_LAST)   // R2
                                   : (hour_r == HOUR_12_LAST);  // R2
    assign hourWrap = clkTick && (sec_r == SEC_LAST)
                      && (min_r == MIN_LAST);
    assign midnight = hourEnd && (ctrl_r.fmt24 || ctrl_r.afternoonFlag);

    always_comb begin
        if (hourEnd) begin
            hourInc = HOUR_RST;
        end else if (hour_r[3:0] == BCD_ONES_LAST) begin         // R17
            hourInc = {hour_r[5:4] + 2'h1, 4'h0};
        end else begin
            hourInc = {hour_r[5:4], hour_r[3:0] + 4'h1};
        end
    end

    // Periodic events
    always_comb begin
        evt          = '0;
        evt.second   = clkTick;
        evt.minute   = clkTick && (sec_r == SEC_LAST);
        evt.hour     = hourWrap;
        evt.day      = hourWrap && midnight;
        evt.week     = hourWrap && midnight && (week_r == WEEK_LAST);
        evt.overflow = frcTick && (frc_r == FRC_LAST);
    end

    // Control byte: top bits survive the ordinary reset pin
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_ONE_RST;
        end else if (!standbyInN) begin
            ctrl_r <= CTRL_ONE_RST;                             // R6
        end else if (wrStb && wb_adr_i == OFS_CTRL_ONE) begin
            // Soft reset bit stays writable so software can leave it
            ctrl_r.softReset <= wb_dat_i[CTRL_ONE_LSB];          // R5
            if (!ctrl_r.softReset && !wb_dat_i[CTRL_ONE_LSB]) begin
                ctrl_r.run           <= wb_dat_i[7];
                ctrl_r.fmt24         <= wb_dat_i[6];
                ctrl_r.afternoonFlag <= wb_dat_i[5];             // R3
            end else begin
                ctrl_r.run           <= 1'b0;                    // R6
                ctrl_r.fmt24         <= 1'b0;
                ctrl_r.afternoonFlag <= 1'b0;
            end
        end else begin
            // Ordinary reset only drops the soft reset bit; the hour
            // keeps counting through it, so the flag must follow
            if (systemResetIn) begin
                ctrl_r.softReset <= 1'b0;
            end
            if (ctrl_r.softReset) begin
                ctrl_r.run           <= 1'b0;                    // R6
                ctrl_r.fmt24         <= 1'b0;
                ctrl_r.afternoonFlag <= 1'b0;
            end else if (evt.hour && !ctrl_r.fmt24 && hourEnd) begin
                ctrl_r.afternoonFlag <= !ctrl_r.afternoonFlag;   // R16
            end
        end
    end

    // Enable byte; the two top bits have no storage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqEn_r <= IRQ_EN_RST;
        end else if (clearClock) begin
            irqEn_r <= IRQ_EN_RST;                               // R7
        end else if (wrStb && wb_adr_i == OFS_IRQ_EN) begin
            irqEn_r <= wb_dat_i[5:0];                            // R18
        end
    end

    // Mode select, outside the soft reset like the source select
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            freeRunMode_r <= MODE_RST;
        end else if (!standbyInN || systemResetIn) begin
            freeRunMode_r <= MODE_RST;
        end else if (wrStb && wb_adr_i == OFS_MODE) begin
            freeRunMode_r <= wb_dat_i[0];
        end
    end

    // Hour count in BCD
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hour_r <= HOUR_RST;
        end else if (ctrl_r.softReset) begin
            hour_r <= HOUR_RST;                                  // R4
        end else if (wrStb && wb_adr_i == OFS_HOUR) begin
            hour_r <= wb_dat_i[5:0];
        end else if (hourWrap) begin
            hour_r <= hourInc;                                   // R16 R17
        end
    end

    // Seconds, minutes and weekday in binary
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sec_r  <= SEC_RST;
            min_r  <= MIN_RST;
            week_r <= WEEK_RST;
        end else if (ctrl_r.softReset) begin
            sec_r  <= SEC_RST;                                   // R4
            min_r  <= MIN_RST;
            week_r <= WEEK_RST;
        end else if (clkTick) begin                              // R1
            sec_r <= (sec_r == SEC_LAST) ? SEC_RST : sec_r + 6'h01;
            if (evt.minute) begin
                min_r <= (min_r == MIN_LAST) ? MIN_RST : min_r + 6'h01;
            end
            if (evt.day) begin
                week_r <= (week_r == WEEK_LAST) ? WEEK_RST
                                                : week_r + 3'h1;
            end
        end
    end

    // Free-running counter used when the clock source is not the crystal
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frc_r <= FRC_RST;
        end else if (ctrl_r.softReset) begin
            frc_r <= FRC_RST;                                    // R4
        end else if (frcTick) begin                              // R1
            frc_r <= frc_r + 8'h01;
        end
    end

    // Sticky status; a new event outranks a clear in the same cycle
    always_comb begin
        statSet.clockIrqRequestFlag =
            (evt.week   && irqEn_r.week)   ||                    // R11
            (evt.day    && irqEn_r.day)    ||                    // R12
            (evt.hour   && irqEn_r.hour)   ||                    // R13
            (evt.minute && irqEn_r.minute) ||                    // R14
            (evt.second && irqEn_r.second);                      // R15
        statSet.overflowFlag = evt.overflow && irqEn_r.overflow; // R10
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_r <= STAT_RST;
        end else if (systemResetIn) begin
            stat_r <= STAT_RST;
        end else if (wrStb && wb_adr_i == OFS_CLEAR) begin
            stat_r <= (stat_r & ~wb_dat_i[1:0]) | statSet;
        end else begin
            stat_r <= stat_r | statSet;                          // R9
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intEn_r <= STAT_RST;
        end else if (systemResetIn) begin
            intEn_r <= STAT_RST;
        end else if (wrStb && wb_adr_i == OFS_INT_EN) begin
            intEn_r <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & intEn_r);
        end
    end

    // Read mux; unmapped words and the clear word read as zero
    always_comb begin
        case (wb_adr_i)
            OFS_CTRL_ONE: rdData = {24'h0, ctrl_r, 4'h0};        // R8
            OFS_IRQ_EN:   rdData = {24'h0, 2'h0, irqEn_r};       // R8
            OFS_HOUR:     rdData = {26'h0, hour_r};
            OFS_TIME:     rdData = {13'h0, week_r, 2'h0, min_r,
                                    2'h0, sec_r};
            OFS_MODE:     rdData = {23'h0, frc_r, freeRunMode_r};
            OFS_STATUS:   rdData = {30'h0, stat_r};
            OFS_INT_EN:   rdData = {30'h0, intEn_r};
            default:      rdData = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= busReq && !ack_r;
            if (busReq && !ack_r) begin
                dat_r <= rdData;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irqOut   = irq_r;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_run_halts: assert property (                               // R1
        !ctrl_r.run && !ctrl_r.softReset
        |=> $stable(sec_r) && $stable(frc_r))
        else $error("counter moved while stopped");

    a_wrap_24h: assert property (                                // R2
        hourWrap && ctrl_r.fmt24 && hour_r == HOUR_24_LAST
        && !wrStb && !clearClock |=> hour_r == HOUR_RST)
        else $error("24-hour count did not wrap at 23");

    a_wrap_12h: assert property (                                // R16
        hourWrap && !ctrl_r.fmt24 && hour_r == HOUR_12_LAST
        && !wrStb && !clearClock && !systemResetIn
        |=> hour_r == HOUR_RST
            && ctrl_r.afternoonFlag != $past(ctrl_r.afternoonFlag))
        else $error("12-hour wrap did not toggle afternoon");

    a_bcd_carry: assert property (                               // R17
        hourWrap && !hourEnd && hour_r[3:0] == BCD_ONES_LAST
        && !wrStb && !clearClock
        |=> hour_r[3:0] == 4'h0
            && hour_r[5:4] == $past(hour_r[5:4]) + 2'h1)
        else $error("hour ones digit did not carry");

    a_soft_hold: assert property (                               // R4
        ctrl_r.softReset ##1 ctrl_r.softReset
        |-> sec_r == SEC_RST && hour_r == HOUR_RST
            && irqEn_r == IRQ_EN_RST && !ctrl_r.run)
        else $error("soft reset did not hold the clock");

    a_standby_clear: assert property (                           // R6 R7
        !standbyInN |=> ctrl_r.run == 1'b0 && ctrl_r.fmt24 == 1'b0
            && ctrl_r.afternoonFlag == 1'b0 && irqEn_r == IRQ_EN_RST)
        else $error("standby did not clear control");

    a_reset_keeps: assert property (                             // R6 R7
        systemResetIn && standbyInN && !ctrl_r.softReset && !wrStb
        && !(evt.hour && !ctrl_r.fmt24 && hourEnd)
        |=> $stable(ctrl_r.run) && $stable(ctrl_r.fmt24)
            && $stable(irqEn_r))
        else $error("ordinary reset changed control");

    a_reserved_zero: assert property (                           // R8 R18
        busReq && !ack_r && !wb_we_i
        && (wb_adr_i == OFS_CTRL_ONE || wb_adr_i == OFS_IRQ_EN)
        |=> wb_ack_o && wb_dat_o[31:8] == 24'h0
            && (wb_adr_i != OFS_CTRL_ONE || wb_dat_o[3:0] == 4'h0)
            && (wb_adr_i != OFS_IRQ_EN || wb_dat_o[7:6] == 2'h0))
        else $error("reserved control bits read nonzero");

    a_event_flag: assert property (                              // R9
        |({evt.week, evt.day, evt.hour, evt.minute, evt.second}
          & {irqEn_r.week, irqEn_r.day, irqEn_r.hour,
             irqEn_r.minute, irqEn_r.second})
        && !systemResetIn |=> stat_r.clockIrqRequestFlag)
        else $error("enabled event lost");

    a_gate_clock: assert property (                   // R11 R12 R13 R14 R15
        !stat_r.clockIrqRequestFlag && !statSet.clockIrqRequestFlag
        |=> !stat_r.clockIrqRequestFlag)
        else $error("clock flag set without enabled event");

    a_gate_overflow: assert property (                           // R10
        evt.overflow && !systemResetIn
        |=> stat_r.overflowFlag == ($past(stat_r.overflowFlag)
            || $past(irqEn_r.overflow)) || $past(wrStb))
        else $error("overflow flag ignores its enable");

    a_irq_level: assert property (
        ##1 irqOut == $past(|(stat_r & intEn_r)))
        else $error("interrupt output mismatch");

    c_second_irq: cover property (statSet.clockIrqRequestFlag ##1 irqOut);
    c_afternoon: cover property (
        hourWrap && !ctrl_r.fmt24 && hourEnd && !ctrl_r.afternoonFlag);
    c_overflow: cover property (evt.overflow && irqEn_r.overflow);
    c_soft_exit: cover property (ctrl_r.softReset ##1 !ctrl_r.softReset);

endmodule // rtc_ctrl_irq

// ==== hw/rtc_pkg.sv ====
// Constants, register map and carrier types of the clock control block
package rtc_pkg;

    // Timing: one time-of-day tick per second at a 125 MHz reference
    localparam longint unsigned CLK_PERIOD_NS   = 64'd8;
    localparam longint unsigned TICK_PERIOD_NS  = 64'd1_000_000_000;
    localparam int unsigned     TICK_CYCLES_DEF =
        int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

    // Wishbone byte addresses of the register words
    localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
    localparam logic [7:0] OFS_HOUR      = 8'h08;
    localparam logic [7:0] OFS_TIME      = 8'h0C;
    localparam logic [7:0] OFS_MODE      = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_CLEAR     = 8'h18;
    localparam logic [7:0] OFS_INT_EN    = 8'h1C;

    // Values after reset
    localparam logic [3:0] CTRL_ONE_RST  = 4'h0;
    localparam logic [5:0] IRQ_EN_RST    = 6'h00;
    localparam logic [5:0] HOUR_RST      = 6'h00;
    localparam logic [5:0] SEC_RST       = 6'h00;
    localparam logic [5:0] MIN_RST       = 6'h00;
    localparam logic [2:0] WEEK_RST      = 3'h0;
    localparam logic [7:0] FRC_RST       = 8'h00;
    localparam logic [1:0] STAT_RST      = 2'h0;
    localparam logic       MODE_RST      = 1'b0;

    // Count limits
    localparam logic [5:0] HOUR_12_LAST  = 6'h11;
    localparam logic [5:0] HOUR_24_LAST  = 6'h23;
    localparam logic [3:0] BCD_ONES_LAST = 4'h9;
    localparam logic [5:0] SEC_LAST      = 6'h3B;
    localparam logic [5:0] MIN_LAST      = 6'h3B;
    localparam logic [2:0] WEEK_LAST     = 3'h6;
    localparam logic [7:0] FRC_LAST      = 8'hFF;

    // Field positions inside the control byte
    localparam int unsigned CTRL_ONE_LSB = 4;

    typedef struct packed {
        logic run;
        logic fmt24;
        logic afternoonFlag;
        logic softReset;
    } rtc_ctrl_one_t;

    // Same order as the enable byte, bits 5 down to 0
    typedef struct packed {
        logic overflow;
        logic week;
        logic day;
        logic hour;
        logic minute;
        logic second;
    } rtc_evt_t;

    typedef struct packed {
        logic overflowFlag;
        logic clockIrqRequestFlag;
    } rtc_stat_t;

endpackage

// ==== sim/rtc_control_and_periodic_irq_bench.sv ====
// Self-checking bench of the clock control and periodic interrupt block
`timescale 1ns/100ps

module rtc_control_and_periodic_irq_bench
    import rtc_pkg::*;
;
    // Short tick so that an hour lasts 14400 cycles
    localparam int unsigned TICKS = 4;

    logic        ref_clk;
    logic        sys_rst;
    logic        standbyInN;
    logic        systemResetIn;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        irqOut;
    logic [31:0] rdat;
    logic [3:0]  selUse;
    int          n_mismatch;
    int          n_compared;

    rtc_ctrl_irq #(.TICK_CYCLES(TICKS)) rtc_ctrl_irq_inst (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .standbyInN    (standbyInN),
        .systemResetIn (systemResetIn),
        .wb_cyc_i      (wbCyc),
        .wb_stb_i      (wbStb),
        .wb_we_i       (wbWe),
        .wb_adr_i      (wbAdr),
        .wb_sel_i      (wbSel),
        .wb_dat_i      (wbDatI),
        .wb_dat_o      (wbDatO),
        .wb_ack_o      (wbAck),
        .irqOut        (irqOut)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask

    // One classic cycle; the bench never assumes the answer latency
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbSel  <= selUse;
        wbAdr  <= a;
        wbDatI <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
        if (n >= 20)
            chk1(1'b0, "no ack");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp, what);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Polling instead of a fixed wait: minute phase is not known here
    task automatic waitHour(input logic [5:0] old);
        int n;
        n = 0;
        do begin
            wb(1'b0, OFS_HOUR, 32'h0);
            n++;
        end while (rdat[5:0] === old && n < 6000);
        chk1(n < 6000, "hour never advanced");
    endtask

    task automatic pollStat(input logic [31:0] exp, input int lim,
                            input string what);
        int n;
        n = 0;
        do begin
            wb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdat !== exp && n < lim);
        chk(rdat, exp, what);
    endtask

    task automatic t_regs;
        rdc(OFS_CTRL_ONE, 32'h0, "control after reset");
        rdc(OFS_IRQ_EN, 32'h0, "enables after reset");
        wr(OFS_CTRL_ONE, 32'h0000_00EF);
        rdc(OFS_CTRL_ONE, 32'h0000_00E0, "control low bits");
        wr(OFS_IRQ_EN, 32'h0000_00FF);
        rdc(OFS_IRQ_EN, 32'h0000_003F, "enable top bits");
        selUse = 4'hE;
        wr(OFS_IRQ_EN, 32'h0);
        selUse = 4'hF;
        rdc(OFS_IRQ_EN, 32'h0000_003F, "low lane off");
        rdc(8'hF0, 32'h0, "unmapped read");
    endtask

    task automatic t_soft;
        wr(OFS_HOUR, 32'h0000_0015);
        wr(OFS_CTRL_ONE, 32'h0000_00F0);
        rdc(OFS_CTRL_ONE, 32'h0000_0010, "soft reset control");
        rdc(OFS_IRQ_EN, 32'h0, "soft reset enables");
        wr(OFS_IRQ_EN, 32'h0000_003F);
        rdc(OFS_IRQ_EN, 32'h0, "enables held");
        rdc(OFS_HOUR, 32'h0, "hour held");
        idle(20);
        rdc(OFS_TIME, 32'h0, "time held");
        wr(OFS_CTRL_ONE, 32'h0);
        rdc(OFS_CTRL_ONE, 32'h0, "soft reset left");
    endtask

    task automatic t_run;
        logic [31:0] t;
        idle(40);
        rdc(OFS_TIME, 32'h0, "stopped clock");
        wr(OFS_CTRL_ONE, 32'h0000_00C0);
        idle(40);
        wb(1'b0, OFS_TIME, 32'h0);
        chk1(rdat[5:0] != 6'h00, "seconds not running");
        wr(OFS_CTRL_ONE, 32'h0000_0040);
        wb(1'b0, OFS_TIME, 32'h0);
        t = rdat;
        idle(40);
        rdc(OFS_TIME, t, "stop holds time");
    endtask

    task automatic t_sec;
        wr(OFS_CLEAR, 32'h3);
        wr(OFS_INT_EN, 32'h1);
        wr(OFS_IRQ_EN, 32'h2);
        wr(OFS_CTRL_ONE, 32'h0000_00C0);
        idle(20);
        rdc(OFS_STATUS, 32'h0, "second masked");
        pollStat(32'h1, 120, "minute event");
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_CLEAR, 32'h1);
        pollStat(32'h1, 20, "second event");
        wr(OFS_IRQ_EN, 32'h0);
        wr(OFS_CLEAR, 32'h1);
        idle(20);
        rdc(OFS_STATUS, 32'h0, "all masked");
    endtask

    task automatic t_noon;
        wr(OFS_CTRL_ONE, 32'h0);
        wr(OFS_HOUR, 32'h0000_0011);
        wr(OFS_IRQ_EN, 32'h4);
        wr(OFS_CLEAR, 32'h3);
        wr(OFS_CTRL_ONE, 32'h0000_0080);
        idle(2);
        chk1(irqOut === 1'b0, "irq before hour");
        waitHour(6'h11);
        chk(rdat, 32'h0, "noon wrap");
        rdc(OFS_CTRL_ONE, 32'h0000_00A0, "afternoon set");
        rdc(OFS_STATUS, 32'h1, "hour event");
        idle(2);
        chk1(irqOut === 1'b1, "irq raised");
        wr(OFS_INT_EN, 32'h0);
        idle(2);
        chk1(irqOut === 1'b0, "irq masked");
        wr(OFS_CLEAR, 32'h1);
        rdc(OFS_STATUS, 32'h0, "status cleared");
    endtask

    task automatic t_bcd;
        wr(OFS_IRQ_EN, 32'h8);
        wr(OFS_HOUR, 32'h0000_0009);
        wr(OFS_CTRL_ONE, 32'h0000_00C0);
        waitHour(6'h09);
        chk(rdat, 32'h0000_0010, "ones carry");
        rdc(OFS_STATUS, 32'h0, "no day event");
        wr(OFS_HOUR, 32'h0000_0023);
        waitHour(6'h23);
        chk(rdat, 32'h0, "midnight wrap");
        rdc(OFS_STATUS, 32'h1, "day event");
    endtask

    task automatic t_free;
        logic [31:0] t;
        wr(OFS_CTRL_ONE, 32'h0);
        wr(OFS_MODE, 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        wr(OFS_CLEAR, 32'h3);
        wr(OFS_INT_EN, 32'h2);
        wr(OFS_CTRL_ONE, 32'h0000_0080);
        idle(1100);
        rdc(OFS_STATUS, 32'h0, "overflow masked");
        wr(OFS_IRQ_EN, 32'h0000_0020);
        idle(1100);
        rdc(OFS_STATUS, 32'h2, "overflow event");
        idle(2);
        chk1(irqOut === 1'b1, "overflow irq");
        wr(OFS_CTRL_ONE, 32'h0);
        wb(1'b0, OFS_MODE, 32'h0);
        t = rdat;
        idle(40);
        rdc(OFS_MODE, t, "free counter stopped");
        wr(OFS_MODE, 32'h0);
        wr(OFS_CLEAR, 32'h3);
    endtask

    task automatic t_pins;
        wr(OFS_CTRL_ONE, 32'h0000_00E0);
        wr(OFS_IRQ_EN, 32'h0000_003F);
        @(posedge ref_clk);
        systemResetIn <= 1'b1;
        idle(3);
        systemResetIn <= 1'b0;
        rdc(OFS_CTRL_ONE, 32'h0000_00E0, "ordinary reset control");
        rdc(OFS_IRQ_EN, 32'h0000_003F, "ordinary reset enables");
        @(posedge ref_clk);
        standbyInN <= 1'b0;
        idle(3);
        standbyInN <= 1'b1;
        rdc(OFS_CTRL_ONE, 32'h0, "standby control");
        rdc(OFS_IRQ_EN, 32'h0, "standby enables");
    endtask

    initial begin
        sys_rst       = 1'b1;
        standbyInN    = 1'b1;
        systemResetIn = 1'b0;
        wbCyc         = 1'b0;
        wbStb         = 1'b0;
        wbWe          = 1'b0;
        wbAdr         = 8'h00;
        wbSel         = 4'hF;
        selUse        = 4'hF;
        wbDatI        = 32'h0;
        n_mismatch    = 0;
        n_compared    = 0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_soft();
        t_run();
        t_sec();
        t_noon();
        t_bcd();
        t_free();
        t_pins();
        finish_test();
    end

    // Three simulated hours plus margin
    initial begin
        #(64'd8 * 64'd80000);
        n_mismatch++;
        $display("ERROR at %0t: watchdog expired", $time);
        finish_test();
    end

endmodule // rtc_control_and_periodic_irq_bench
